//--- startup_supervisor_pkg.sv
// Package: constants and carrier types for the startup and error supervisor
`default_nettype none
package startup_supervisor_pkg;
    // Reference clock and sequencing clock
    localparam int unsigned REF_CLK_HZ       = 10_000_000;
    localparam int unsigned SEQ_CLK_HZ       = 200_000;
    localparam int unsigned SEQ_DIV_CYCLES   = REF_CLK_HZ / SEQ_CLK_HZ;
    // Startup time in microseconds, counted in sequencing ticks (rounded down)
    localparam int unsigned STARTUP_TIME_US  = 40;
    localparam int unsigned STARTUP_TICKS    = (STARTUP_TIME_US * (SEQ_CLK_HZ / 1000)) / 1000 > 0 ?
                                               (STARTUP_TIME_US * (SEQ_CLK_HZ / 1000)) / 1000 : 1;
    // Self-test square wave: 24 Hz, half period in sequencing ticks
    localparam int unsigned SELF_TEST_HZ     = 24;
    localparam int unsigned ST_HALF_TICKS    = SEQ_CLK_HZ / (2 * SELF_TEST_HZ);
    // Output codes: 12-bit output, mid-supply and self-test step of 1.3 g peak-to-peak
    localparam int unsigned OUT_W            = 12;
    localparam logic [11:0] OUT_MID          = 12'h800;
    localparam logic [11:0] ST_STEP          = 12'h02C;
    localparam int unsigned DIV_W            = 6;
    localparam int unsigned SEQ_W            = 4;
    localparam int unsigned ST_W             = 13;
    localparam logic [DIV_W-1:0] DIV_LAST    = DIV_W'(SEQ_DIV_CYCLES - 1);
    localparam logic [SEQ_W-1:0] SEQ_LAST    = SEQ_W'(STARTUP_TICKS - 1);
    localparam logic [ST_W-1:0]  ST_LAST     = ST_W'(ST_HALF_TICKS - 1);

    typedef enum {SEQ_OFF, SEQ_START, SEQ_RUN} seq_state_t;

    typedef struct packed {
        logic [11:0] pos;
        logic [11:0] neg;
    } diff_out_t;
endpackage : startup_supervisor_pkg
`default_nettype wire

//--- sensor_startup_error_supervisor.sv
// Startup sequencer, reset and self-test output control and error flag
//
// Behaviour
// - External reset is active low; undriven it reads inactive high.
// - Self-test input is active high; undriven it reads inactive low.
// - Power-good stays low below threshold, then goes high and startup begins.
// - After a supply drop, power-good low until recovery, then full new startup.
// - Error flag high from power-on until startup sequence finishes.
// - External reset forces both outputs to mid-supply and error high.
// - Self-test adds a 24 Hz, 1.3 g peak-to-peak square wave.
// - Error high while power-good low, reset active, or overload present.
// - Overload resets readout and restarts startup until input is in range.
// - Sensor operational about 40 us after power-on detection.
// - Sequencing logic ticks at 200 kHz from the reference clock.
`timescale 1ns/10ps
`default_nettype none
module sensor_startup_error_supervisor
    import startup_supervisor_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        supply_above_threshold,
    input  wire logic        ext_reset_n_in,
    input  wire logic        self_test_in,
    input  wire logic        overload_detect,
    input  wire logic [11:0] accel_in_pos,
    input  wire logic [11:0] accel_in_neg,
    output logic             power_good,
    output logic             error_flag,
    output logic             readout_reset,
    output logic [11:0]      accel_out_pos,
    output logic [11:0]      accel_out_neg
);
    // Any cause that invalidates outputs and restarts the sequence
    logic abort;
    assign abort = !supply_above_threshold || !ext_reset_n_in || overload_detect;

    // Sequencing tick divider
    logic [DIV_W-1:0] div_q, div_d;
    logic             tick;
    always_comb begin
        tick  = (div_q == DIV_LAST);
        div_d = tick ? '0 : div_q + DIV_W'(1);
    end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end

    // Startup sequence counter
    seq_state_t       state_q, state_d;
    logic [SEQ_W-1:0] seq_q, seq_d;
    logic             pg_q, pg_d;
    logic             err_q, err_d;
    logic             rdrst_q, rdrst_d;
    always_comb begin
        state_d = state_q;
        seq_d   = seq_q;
        pg_d    = supply_above_threshold;
        case (state_q)
            SEQ_OFF: begin
                seq_d = '0;
                if (supply_above_threshold && ext_reset_n_in && !overload_detect) begin
                    state_d = SEQ_START;
                end
            end
            SEQ_START: begin
                if (abort) begin
                    state_d = SEQ_OFF;
                    seq_d   = '0;
                end else if (tick) begin
                    if (seq_q == SEQ_LAST) begin
                        state_d = SEQ_RUN;
                    end else begin
                        seq_d = seq_q + SEQ_W'(1);
                    end
                end
            end
            SEQ_RUN: begin
                if (abort) begin
                    state_d = SEQ_OFF;
                    seq_d   = '0;
                end
            end
            default: begin
                state_d = SEQ_OFF;
                seq_d   = '0;
            end
        endcase
        // Error clears only once the running state is reached and no cause stands
        err_d   = !(state_d == SEQ_RUN);
        rdrst_d = overload_detect || (state_d == SEQ_OFF);
    end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= SEQ_OFF;
            seq_q   <= '0;
            pg_q    <= 1'b0;
            err_q   <= 1'b1;
            rdrst_q <= 1'b1;
        end else begin
            state_q <= state_d;
            seq_q   <= seq_d;
            pg_q    <= pg_d;
            err_q   <= err_d;
            rdrst_q <= rdrst_d;
        end
    end

    // Self-test square wave generator; runs only while self-test is held
    logic [ST_W-1:0] st_cnt_q, st_cnt_d;
    logic            st_phase_q, st_phase_d;
    always_comb begin
        st_cnt_d   = st_cnt_q;
        st_phase_d = st_phase_q;
        if (!self_test_in) begin
            st_cnt_d   = '0;
            st_phase_d = 1'b0;
        end else if (tick) begin
            if (st_cnt_q == ST_LAST) begin
                st_cnt_d   = '0;
                st_phase_d = !st_phase_q;
            end else begin
                st_cnt_d = st_cnt_q + ST_W'(1);
            end
        end
    end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_cnt_q   <= '0;
            st_phase_q <= 1'b0;
        end else begin
            st_cnt_q   <= st_cnt_d;
            st_phase_q <= st_phase_d;
        end
    end

    // Output path; stimulus is added on top of real acceleration, so test only at rest
    diff_out_t out_q, out_d;
    always_comb begin
        out_d.pos = accel_in_pos;
        out_d.neg = accel_in_neg;
        if (!ext_reset_n_in) begin
            out_d.pos = OUT_MID;
            out_d.neg = OUT_MID;
        end else if (self_test_in) begin
            out_d.pos = st_phase_q ? accel_in_pos + ST_STEP : accel_in_pos - ST_STEP;
            out_d.neg = st_phase_q ? accel_in_neg - ST_STEP : accel_in_neg + ST_STEP;
        end
    end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            out_q <= '{pos: OUT_MID, neg: OUT_MID};
        end else begin
            out_q <= out_d;
        end
    end

    assign power_good    = pg_q;
    assign error_flag    = err_q;
    assign readout_reset = rdrst_q;
    assign accel_out_pos = out_q.pos;
    assign accel_out_neg = out_q.neg;

    // Startup length counter used only by assertions; saturates so it never wraps to a short count
    logic [15:0] run_len_q, run_len_d;
    always_comb begin
        run_len_d = run_len_q;
        if (abort || state_q == SEQ_OFF) begin
            run_len_d = '0;
        end else if (run_len_q != 16'hFFFF) begin
            run_len_d = run_len_q + 16'h0001;
        end
    end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            run_len_q <= '0;
        end else begin
            run_len_q <= run_len_d;
        end
    end

    a_reset_mid_out: assert property (@(posedge ref_clk) disable iff (!resetn)
        !ext_reset_n_in |=> (accel_out_pos == OUT_MID && accel_out_neg == OUT_MID && error_flag))
        else $error("outputs not at mid-supply during external reset");
    a_err_on_cause: assert property (@(posedge ref_clk) disable iff (!resetn)
        abort |=> error_flag)
        else $error("error flag low while a cause is present");
    a_pg_follows: assert property (@(posedge ref_clk) disable iff (!resetn)
        !supply_above_threshold |=> !power_good)
        else $error("power good high below threshold");
    a_err_till_done: assert property (@(posedge ref_clk) disable iff (!resetn)
        $fell(error_flag) |-> run_len_q >= 16'(STARTUP_TICKS * SEQ_DIV_CYCLES - SEQ_DIV_CYCLES))
        else $error("error released before startup finished");
    a_startup_bound: assert property (@(posedge ref_clk) disable iff (!resetn)
        run_len_q > 16'(STARTUP_TICKS * SEQ_DIV_CYCLES + SEQ_DIV_CYCLES + 2) |-> !error_flag)
        else $error("startup exceeded its length");
    a_overload_rst: assert property (@(posedge ref_clk) disable iff (!resetn)
        overload_detect |=> readout_reset && state_q == SEQ_OFF)
        else $error("overload did not reset readout");
    a_restart_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(power_good) |-> error_flag ##1 error_flag)
        else $error("sequence did not restart after supply recovery");
    a_tick_period: assert property (@(posedge ref_clk) disable iff (!resetn)
        tick |=> !tick [*2])
        else $error("sequencing tick too frequent");
    a_st_steady: assert property (@(posedge ref_clk) disable iff (!resetn)
        (self_test_in && !tick) |=> st_phase_q == $past(st_phase_q))
        else $error("self-test phase changed off tick");
    a_st_toggle: assert property (@(posedge ref_clk) disable iff (!resetn)
        (self_test_in && tick && st_cnt_q == ST_LAST) |=> st_phase_q != $past(st_phase_q))
        else $error("self-test phase did not toggle at half period");
    a_out_follow: assert property (@(posedge ref_clk) disable iff (!resetn)
        (ext_reset_n_in && !self_test_in) |=> (accel_out_pos == $past(accel_in_pos) && accel_out_neg == $past(accel_in_neg)))
        else $error("outputs altered without self-test or reset");
    a_tick_rate: assert property (@(posedge ref_clk) disable iff (!resetn)
        tick |-> ##50 tick)
        else $error("sequencing tick period wrong");
endmodule : sensor_startup_error_supervisor
`default_nettype wire

//--- host_model.sv
// Host controller model driving external reset and self-test request
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input  wire logic ref_clk,
    input  wire logic drive_en,
    input  wire logic rst_req,
    input  wire logic st_req,
    input  wire logic stationary,
    output var logic  ext_reset_n_in,
    output var logic  self_test_in
);
    // Undriven pins fall back to their pull levels
    always @(posedge ref_clk) begin
        ext_reset_n_in <= drive_en ? !rst_req : 1'b1;
        self_test_in   <= drive_en ? (st_req && stationary) : 1'b0;
    end
endmodule : host_model
`default_nettype wire

//--- sensor_startup_error_supervisor_bench.sv
// Self-checking bench for the startup and error supervisor
`timescale 1ns/10ps
`default_nettype none
module sensor_startup_error_supervisor_bench;
    import startup_supervisor_pkg::*;
    // First tick lands 1..50 cycles into the start state, then seven more ticks follow
    localparam int LO = (STARTUP_TICKS - 1) * SEQ_DIV_CYCLES + 2;
    localparam int HI = STARTUP_TICKS * SEQ_DIV_CYCLES + 1;
    logic ref_clk = 1'b0, resetn = 1'b0, supply = 1'b0, ovl = 1'b0, drv = 1'b1, rst_req = 1'b0, st_req = 1'b0;
    logic [11:0] in_p = 12'h800, in_n = 12'h800;
    wire logic ext_n, st_in, pg, err, rr;
    wire logic [11:0] out_p, out_n;
    int error_cnt = 0, n_compared = 0, seed = 32'hF964;
    always #50 ref_clk = ~ref_clk;
    host_model HOST (.ref_clk(ref_clk), .drive_en(drv), .rst_req(rst_req), .st_req(st_req),
        .stationary(!ovl), .ext_reset_n_in(ext_n), .self_test_in(st_in));
    sensor_startup_error_supervisor DUT (.ref_clk(ref_clk), .resetn(resetn), .supply_above_threshold(supply),
        .ext_reset_n_in(ext_n), .self_test_in(st_in), .overload_detect(ovl), .accel_in_pos(in_p),
        .accel_in_neg(in_n), .power_good(pg), .error_flag(err), .readout_reset(rr),
        .accel_out_pos(out_p), .accel_out_neg(out_n));
    task step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step
    task chk_bit(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit
    task chk_code(input string nm, input logic [11:0] e, input logic [11:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_code
    // Reference model: offset d added to pos, taken from neg, no saturation
    task chk_out(input int d);
        int ep, en;
        ep = int'(in_p) + d;
        en = int'(in_n) - d;
        chk_code("accel_out_pos", 12'(ep), out_p);
        chk_code("accel_out_neg", 12'(en), out_n);
    endtask : chk_out
    // Counts from removal of the last cause, so a restarted count shows as a long wait
    // Lag is the extra cycle a cause spends passing through the host model
    task chk_clear(input int lag);
        int c;
        c = 0;
        while (err !== 1'b0 && c < 1000) begin
            step(1);
            c++;
        end
        chk_bit("error_clear_time", 1'b1, c >= LO + lag && c <= HI + lag);
    endtask : chk_clear
    task close_out();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    initial begin
        #2_000_000;
        error_cnt++;
        close_out();
    end
    initial begin
        step(20);
        chk_code("reset_out", 12'h800, out_p);
        chk_bit("reset_err", 1'b1, err);
        resetn = 1;
        step(3);
        chk_bit("power_good", 1'b0, pg);
        chk_bit("error_flag", 1'b1, err);
        supply = 1;
        step(2);
        chk_bit("power_good", 1'b1, pg);
        step(200);
        chk_bit("error_flag", 1'b1, err);
        supply = 0;
        step(2);
        chk_bit("power_good", 1'b0, pg);
        chk_bit("error_flag", 1'b1, err);
        supply = 1;
        chk_clear(0);
        $display("test power_sequence done");
        repeat (4) begin
            in_p = 12'($random(seed));
            in_n = 12'($random(seed));
            step(2);
            chk_out(0);
        end
        rst_req = 1;
        step(3);
        chk_code("accel_out_pos", OUT_MID, out_p);
        chk_code("accel_out_neg", OUT_MID, out_n);
        chk_bit("error_flag", 1'b1, err);
        rst_req = 0;
        chk_clear(1);
        $display("test external_reset done");
        ovl = 1;
        step(2);
        chk_bit("error_flag", 1'b1, err);
        chk_bit("readout_reset", 1'b1, rr);
        step(300);
        chk_bit("error_flag", 1'b1, err);
        ovl = 0;
        chk_clear(0);
        chk_bit("readout_reset", 1'b0, rr);
        $display("test overload done");
        st_req = 1;
        step(4);
        chk_out(-int'(ST_STEP));
        st_req = 0;
        step(4);
        chk_out(0);
        // Requests stand while released, so only the pulls can keep reset and self-test off
        rst_req = 1;
        st_req = 1;
        drv = 0;
        step(4);
        chk_bit("error_flag", 1'b0, err);
        chk_out(0);
        $display("test self_test_and_pulls done");
        close_out();
    end
endmodule : sensor_startup_error_supervisor_bench
`default_nettype wire
